// [src/dtc_pkg.sv]
`default_nettype none
package dtc_pkg;
    // register map, byte addresses on the bus
    localparam logic [7:0] DTC_CTRL_OFS = 8'h00;
    localparam logic [7:0] DTC_STAT_OFS = 8'h04;
    // control field positions for timer a, plus the calendar enable; timer b sits one byte higher
    localparam int DTC_RUN_BIT = 0;
    localparam int DTC_FREEZE_BIT = 1;
    localparam int DTC_EDGE_LSB = 2;
    localparam int DTC_INV_BIT = 6;
    localparam int DTC_B_SHIFT = 8;
    localparam int DTC_RTC_BIT = 4;
    // only these control bits hold state; all others read zero
    localparam logic [31:0] DTC_WR_MASK = 32'h0000_4f5f;
    localparam logic [31:0] DTC_CTRL_RST = 32'h0000_0000;
    // status field positions
    localparam int DTC_ST_ADV_LSB = 0;
    localparam int DTC_ST_HALT_BIT = 2;
    localparam int DTC_ST_RTC_BIT = 3;
    // capture edge encodings
    localparam logic [1:0] DTC_EDGE_RISE = 2'h0;
    localparam logic [1:0] DTC_EDGE_FALL = 2'h1;
    localparam logic [1:0] DTC_EDGE_RESV = 2'h2;
    localparam logic [1:0] DTC_EDGE_BOTH = 2'h3;
endpackage
`default_nettype wire

// [src/dtc_ctl_if.sv]
`timescale 1ns/1ps
`default_nettype none
// per-timer control fields from the register file to a gate unit
interface dtc_ctl_if;
    logic run;
    logic freeze;
    logic [1:0] edge_sel;
    logic invert;
    modport ctrl (output run, output freeze, output edge_sel, output invert);
    modport gate (input run, input freeze, input edge_sel, input invert);
endinterface
`default_nettype wire

// [src/dtc_timer_gate.sv]
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_gate (
    input wire logic clk_i,         // system clock
    input wire logic rst_i,         // synchronous reset, high
    dtc_ctl_if.gate ctl,            // control fields for this timer
    input wire logic halt_i,        // processor halted by debugger
    input wire logic pwm_raw_i,     // pwm from counting datapath
    input wire logic capture_pin_i, // capture input pin
    output logic advance_o,         // counter may advance this cycle
    output logic capture_evt_o,     // selected capture edge seen
    output logic pwm_o              // pwm after polarity
);
    logic pin_q;
    logic rise;
    logic fall;

    // counting allowed when enabled and not frozen by a debug halt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            advance_o <= 1'b0;
        end else begin
            advance_o <= ctl.run && !(halt_i && ctl.freeze);
        end
    end

    // previous pin level for edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= capture_pin_i;
        end
    end

    assign rise = capture_pin_i && !pin_q;
    assign fall = !capture_pin_i && pin_q;

    // capture event per edge selection; reserved code never fires
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_evt_o <= 1'b0;
        end else begin
            case (ctl.edge_sel)
                dtc_pkg::DTC_EDGE_RISE: capture_evt_o <= ctl.run && rise;
                dtc_pkg::DTC_EDGE_FALL: capture_evt_o <= ctl.run && fall;
                dtc_pkg::DTC_EDGE_BOTH: capture_evt_o <= ctl.run && (rise || fall);
                default: capture_evt_o <= 1'b0;
            endcase
        end
    end

    // output polarity
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_o <= 1'b0;
        end else begin
            pwm_o <= pwm_raw_i ^ ctl.invert;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    run_gate_a: assert property (!ctl.run |=> !advance_o)
        else $error("timer advanced while disabled");
    halt_freeze_a: assert property (ctl.freeze && halt_i |=> !advance_o)
        else $error("timer advanced during halt with freeze set");
    halt_count_a: assert property (ctl.run && halt_i && !ctl.freeze |=> advance_o)
        else $error("timer stopped during halt without freeze");
    normal_run_a: assert property (ctl.run && !halt_i |=> advance_o)
        else $error("freeze bit acted without a halt");
    edge_rise_a: assert property (ctl.run && ctl.edge_sel == dtc_pkg::DTC_EDGE_RISE && rise
            |=> capture_evt_o)
        else $error("rising edge missed");
    edge_fall_a: assert property (ctl.edge_sel == dtc_pkg::DTC_EDGE_RISE && fall
            |=> !capture_evt_o)
        else $error("falling edge taken in rising mode");
    edge_resv_a: assert property (ctl.edge_sel == dtc_pkg::DTC_EDGE_RESV |=> !capture_evt_o)
        else $error("event from reserved edge code");
    pwm_invert_a: assert property (##1 pwm_o == ($past(pwm_raw_i) ^ $past(ctl.invert)))
        else $error("pwm polarity wrong");
endmodule
`default_nettype wire

// [src/dtc_top.sv]
// What this block does
// - timer a runs only when its enable set
// - timer b runs only when its enable set
// - timer a freeze bit holds count during halt
// - timer b freeze bit holds count during halt
// - freeze bits ignored when processor not halted
// - timer a capture edge: rise, fall, both
// - timer b capture edge, same encoding
// - timer a pwm inverted when its bit set
// - timer b pwm inverted when its bit set
// - clock calendar advances only when enabled
// - reserved control bits read as zero
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module dtc_top (
    input wire logic clk_i,              // system clock, 50 mhz
    input wire logic rst_i,              // synchronous reset, high
    input wire logic wb_cyc_i,           // wishbone cycle
    input wire logic wb_stb_i,           // wishbone strobe
    input wire logic wb_we_i,            // wishbone write
    input wire logic [7:0] wb_adr_i,     // wishbone byte address
    input wire logic [3:0] wb_sel_i,     // wishbone byte enables
    input wire logic [31:0] wb_dat_i,    // wishbone write data
    output logic [31:0] wb_dat_o,        // wishbone read data
    output logic wb_ack_o,               // wishbone acknowledge
    input wire logic debug_halt_i,       // processor halted by debugger
    input wire logic [1:0] pwm_raw_i,    // raw pwm, bit0 timer a
    input wire logic [1:0] capture_pin_i, // capture pins, bit0 timer a
    input wire logic rtc_tick_i,         // calendar tick request
    output logic [1:0] timer_run_o,      // enable bits to datapath
    output logic [1:0] timer_advance_o,  // count enable per timer
    output logic [1:0] capture_evt_o,    // capture event per timer
    output logic [1:0] pwm_o,            // pwm after polarity
    output logic rtc_advance_o           // calendar count step
);
    logic [31:0] ctrl_q;
    logic [31:0] lane_mask;
    logic [31:0] stat_word;
    logic access;
    logic [1:0] adv_w;
    logic [1:0] evt_w;
    logic [1:0] pwm_w;
    logic [1:0] run_q;

    // byte enables expanded to a bit mask
    function automatic logic [31:0] lanes(input logic [3:0] sel);
        lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // one new request per handshake; ack drops the cycle after it is given
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign lane_mask = lanes(wb_sel_i) & dtc_pkg::DTC_WR_MASK;

    // control register: only writable fields take data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= dtc_pkg::DTC_CTRL_RST;
        end else if (access && wb_we_i && wb_adr_i == dtc_pkg::DTC_CTRL_OFS) begin
            ctrl_q <= (ctrl_q & ~lane_mask) | (wb_dat_i & lane_mask);
        end
    end

    // status word shows live gating state
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[dtc_pkg::DTC_ST_ADV_LSB +: 2] = timer_advance_o;
        stat_word[dtc_pkg::DTC_ST_HALT_BIT] = debug_halt_i;
        stat_word[dtc_pkg::DTC_ST_RTC_BIT] = ctrl_q[dtc_pkg::DTC_RTC_BIT];
    end

    // bus answer: one wait state, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= access;
            if (access && !wb_we_i) begin
                case (wb_adr_i)
                    dtc_pkg::DTC_CTRL_OFS: wb_dat_o <= ctrl_q & dtc_pkg::DTC_WR_MASK;
                    dtc_pkg::DTC_STAT_OFS: wb_dat_o <= stat_word;
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // calendar tick passes only while the calendar enable bit is set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rtc_advance_o <= 1'b0;
        end else begin
            rtc_advance_o <= rtc_tick_i && ctrl_q[dtc_pkg::DTC_RTC_BIT];
        end
    end

    // registered copy of the enable bits for the datapath
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= 2'b00;
        end else begin
            run_q[0] <= ctrl_q[dtc_pkg::DTC_RUN_BIT];
            run_q[1] <= ctrl_q[dtc_pkg::DTC_RUN_BIT + dtc_pkg::DTC_B_SHIFT];
        end
    end

    // one gate unit per sub-timer, fields of b one byte above a
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_tmr
            localparam int OFS = i * dtc_pkg::DTC_B_SHIFT;
            dtc_ctl_if ctl_if ();
            assign ctl_if.run = ctrl_q[dtc_pkg::DTC_RUN_BIT + OFS];
            assign ctl_if.freeze = ctrl_q[dtc_pkg::DTC_FREEZE_BIT + OFS];
            assign ctl_if.edge_sel = ctrl_q[dtc_pkg::DTC_EDGE_LSB + OFS +: 2];
            assign ctl_if.invert = ctrl_q[dtc_pkg::DTC_INV_BIT + OFS];
            dtc_timer_gate u_gate (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ctl(ctl_if),
                .halt_i(debug_halt_i),
                .pwm_raw_i(pwm_raw_i[i]),
                .capture_pin_i(capture_pin_i[i]),
                .advance_o(adv_w[i]),
                .capture_evt_o(evt_w[i]),
                .pwm_o(pwm_w[i])
            );
        end
    endgenerate

    // outputs taken from the gate flip-flops, run bits from run_q
    assign timer_advance_o = adv_w;
    assign capture_evt_o = evt_w;
    assign pwm_o = pwm_w;
    assign timer_run_o = run_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    rtc_gate_a: assert property (!ctrl_q[dtc_pkg::DTC_RTC_BIT] |=> !rtc_advance_o)
        else $error("calendar advanced while disabled");
    rtc_pass_a: assert property (ctrl_q[dtc_pkg::DTC_RTC_BIT] && rtc_tick_i |=> rtc_advance_o)
        else $error("calendar tick lost while enabled");
    resv_zero_a: assert property ((ctrl_q & ~dtc_pkg::DTC_WR_MASK) == 32'h0000_0000)
        else $error("reserved control bit holds state");
    resv_read_a: assert property (access && !wb_we_i && wb_adr_i == dtc_pkg::DTC_CTRL_OFS
            |=> (wb_dat_o & ~dtc_pkg::DTC_WR_MASK) == 32'h0000_0000)
        else $error("reserved control bit read nonzero");
    stat_read_a: assert property (access && !wb_we_i && wb_adr_i == dtc_pkg::DTC_STAT_OFS
            |=> wb_dat_o == $past(stat_word))
        else $error("status read does not match live state");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside acknowledge");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_timely_a: assert property (access |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    reset_clear_a: assert property (disable iff (1'b0)
            rst_i |=> ctrl_q == dtc_pkg::DTC_CTRL_RST)
        else $error("control not cleared by reset");
endmodule
`default_nettype wire

// [verif/dtc_sw_model.sv]
`timescale 1ns/1ps
`default_nettype none
// software side: classic wishbone master issuing single word transfers
module dtc_sw_model (
    input wire logic clk_i,          // system clock
    input wire logic ack_i,          // slave acknowledge
    input wire logic [31:0] dat_i,   // slave read data
    output logic cyc_o,              // cycle
    output logic stb_o,              // strobe
    output logic we_o,               // write
    output logic [7:0] adr_o,        // byte address
    output logic [3:0] sel_o,        // byte enables
    output logic [31:0] dat_o        // write data
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'hf;
        dat_o = 32'h0;
    end
    // hold the request until ack is seen at an edge, then release
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= we;
        sel_o <= 4'hf;
        adr_o <= a;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [verif/dtc_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module dtc_top_bench;
    logic clk_i = 1'b0, rst_i = 1'b1, halt = 1'b0, tick = 1'b0;
    logic cyc, stb, we, ack;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, ctl, q;
    logic [1:0] raw = 2'h0, pin = 2'h0, run, adv, evt, pwm;
    logic rtc;
    logic [1:0] adv_e;
    logic [31:0] expq[$];
    int error_cnt = 0, num_checks = 0, seed = 54403;
    initial forever #10 clk_i = ~clk_i;
    dtc_sw_model sw (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    dtc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .debug_halt_i(halt), .pwm_raw_i(raw), .capture_pin_i(pin), .rtc_tick_i(tick),
        .timer_run_o(run), .timer_advance_o(adv), .capture_evt_o(evt), .pwm_o(pwm),
        .rtc_advance_o(rtc));
    // compare one value and count it
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // note the expected word, then read it over the bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        sw.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic wr(input logic [31:0] d);
        ctl = d & dtc_pkg::DTC_WR_MASK;
        sw.xfer(1'b1, dtc_pkg::DTC_CTRL_OFS, d, q);
    endtask
    // watcher: every read acknowledge takes the oldest note
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (expq.size() == 0) chk(rdat, 32'hdead_beef);
            else chk(rdat, expq.pop_front());
        end
    end
    task automatic results();
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        results();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(dtc_pkg::DTC_CTRL_OFS, 32'h0);
        rd(8'h08, 32'h0);
        wr(32'hffff_ffff);
        rd(dtc_pkg::DTC_CTRL_OFS, 32'h0000_4f5f);
        // random fields and inputs, outputs against the field meanings
        repeat (24) begin
            wr($random(seed));
            rd(dtc_pkg::DTC_CTRL_OFS, ctl);
            @(posedge clk_i);
            {halt, tick, raw} <= 4'($random(seed));
            repeat (2) @(posedge clk_i);
            #1;
            chk(run, {ctl[8], ctl[0]});
            adv_e = {ctl[8], ctl[0]} & ~({2{halt}} & {ctl[9], ctl[1]});
            chk(adv, adv_e);
            chk(pwm, raw ^ {ctl[14], ctl[6]});
            chk(rtc, tick & ctl[4]);
            // status word: advance bits, halt level, calendar enable
            rd(dtc_pkg::DTC_STAT_OFS, {28'h0, ctl[4], halt, adv_e});
        end
        // every edge code on both timers: a rise then a fall
        for (int c = 0; c < 4; c++) begin
            wr(32'h0000_0101 | (c << 2) | (c << 10));
            @(posedge clk_i);
            pin <= 2'h3;
            @(posedge clk_i);
            #1;
            chk(evt, {2{c == 0 || c == 3}});
            @(posedge clk_i);
            pin <= 2'h0;
            @(posedge clk_i);
            #1;
            chk(evt, {2{c == 1 || c == 3}});
        end
        // second reset in mid-run clears every field again
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(dtc_pkg::DTC_CTRL_OFS, 32'h0);
        #1;
        chk({run, adv, evt, rtc}, 32'h0);
        repeat (3) @(posedge clk_i);
        results();
    end
endmodule
`default_nettype wire
